// ### uart_bus_port_pkg.sv
// Shared constants for the parallel host bus port of the serial controller
package uart_bus_port_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_W      = 3;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned PTR_W       = 5;
  localparam int unsigned ERR_W       = 3;

  // ****************************************
  // Register offsets and fields
  // ****************************************
  localparam logic [2:0] DATA_OFFSET   = 3'h0;
  localparam logic [2:0] STATUS_OFFSET = 3'h5;
  localparam int unsigned STAT_RX_AVAIL_POS = 0;
  localparam int unsigned STAT_RX_ERR_POS   = 1;
  localparam int unsigned STAT_TX_EMPTY_POS = 5;
  localparam int unsigned STAT_TX_FULL_POS  = 6;
  localparam logic [7:0] DATA_RESET     = 8'h00;
  localparam logic [7:0] IDLE_BUS_VALUE = 8'hff;

  // ****************************************
  // Timing of one host access
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned SETUP_TIME_NS  = 60;
  localparam int unsigned STROBE_TIME_NS = 160;
  localparam int unsigned RECOV_TIME_NS  = 80;
  localparam int unsigned SETUP_CYCLES  = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYCLES = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOV_CYCLES  = (RECOV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 4;

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_LATCH, H_STROBE, H_RECOV
  } host_state_t;

endpackage

// ### uart_bus_port_if.sv
// Pin bundle between the bus port and the controlling host
interface uart_bus_port_if;
  import uart_bus_port_pkg::*;

  logic              reg_select_bit0;
  logic              reg_select_bit1;
  logic              reg_select_bit2;
  logic              read_strobe_hi;
  logic              read_strobe_lo;
  logic              write_strobe_hi;
  logic              write_strobe_lo;
  logic              select_high_a;
  logic              select_high_b;
  logic              select_low_c;
  logic              addr_latch_strobe;
  logic              drive_disable_n;
  logic [DATA_W-1:0] host_data_out;
  logic              host_data_oe_n;
  logic [DATA_W-1:0] dev_data_out;
  logic              dev_data_oe_n;
  logic [DATA_W-1:0] host_data_bus;

  // Bus level resolved from both enables; undriven bus floats high
  assign host_data_bus = !dev_data_oe_n  ? dev_data_out  :
                         !host_data_oe_n ? host_data_out : IDLE_BUS_VALUE;

  modport device_end (
    input  reg_select_bit0, reg_select_bit1, reg_select_bit2,
    input  read_strobe_hi, read_strobe_lo, write_strobe_hi, write_strobe_lo,
    input  select_high_a, select_high_b, select_low_c, addr_latch_strobe,
    input  host_data_bus,
    output dev_data_out, dev_data_oe_n, drive_disable_n
  );

  modport host_end (
    output reg_select_bit0, reg_select_bit1, reg_select_bit2,
    output read_strobe_hi, read_strobe_lo, write_strobe_hi, write_strobe_lo,
    output select_high_a, select_high_b, select_low_c, addr_latch_strobe,
    output host_data_out, host_data_oe_n,
    input  host_data_bus, drive_disable_n
  );

endinterface

// ### uart_bus_port_dev.sv
// Device end of the parallel host bus port with transmit and receive buffers

// Notes on behaviour
// - Three address bits pick the register
// - Selected only when both highs high, low low
// - Host ties unused selects to active level
// - Read when high strobe high or low strobe low
// - Host using low read holds high at 0
// - Write when high strobe high or low low
// - Host using low write holds high at 0
// - Latch strobe rise captures selects and address
// - Latch strobe tied low makes decode transparent
// - Bit zero is least significant, first serial
// - Transmit buffer holds sixteen bytes
// - Receive buffer holds sixteen bytes with errors
// - Drive disable low while host reads
// - Reset clears all registers and outputs except the tx_mem and rx_mem buffer storage
module uart_bus_port_dev
  import uart_bus_port_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              resetn_in,
  uart_bus_port_if.device_end    bus,
  output logic [DATA_W-1:0]      tx_data_out,
  output logic                   tx_valid_out,
  input  wire logic              tx_ready_in,
  input  wire logic [DATA_W-1:0] rx_data_in,
  input  wire logic [ERR_W-1:0]  rx_err_in,
  input  wire logic              rx_valid_in,
  output logic                   rx_ready_out,
  output logic                   reg_wr_valid_out,
  output logic [ADDR_W-1:0]      reg_wr_addr_out,
  output logic [DATA_W-1:0]      reg_wr_data_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int unsigned PIN_W = 11 + DATA_W;

  logic [PIN_W-1:0] pin_meta_r;
  logic [PIN_W-1:0] pin_sync_r;
  logic [PIN_W-1:0] pin_raw;

  assign pin_raw = {bus.addr_latch_strobe, bus.select_low_c, bus.select_high_b,
                    bus.select_high_a, bus.reg_select_bit2, bus.reg_select_bit1,
                    bus.reg_select_bit0, bus.read_strobe_hi, bus.read_strobe_lo,
                    bus.write_strobe_hi, bus.write_strobe_lo, bus.host_data_bus};

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  logic              latch_s;
  logic              live_sel;
  logic [ADDR_W-1:0] live_addr;
  logic              rd_req;
  logic              wr_req;
  logic [DATA_W-1:0] wdata;

  assign latch_s   = pin_sync_r[PIN_W-1];
  assign live_sel  = pin_sync_r[PIN_W-3] & pin_sync_r[PIN_W-4] & ~pin_sync_r[PIN_W-2];
  assign live_addr = pin_sync_r[PIN_W-5:PIN_W-7];
  assign rd_req    = pin_sync_r[DATA_W+3] | ~pin_sync_r[DATA_W+2];
  assign wr_req    = pin_sync_r[DATA_W+1] | ~pin_sync_r[DATA_W];
  assign wdata     = pin_sync_r[DATA_W-1:0];

  // ****************************************
  // Address and select latch
  // ****************************************
  logic              latch_prev_r;
  logic              lat_sel_r;
  logic [ADDR_W-1:0] lat_addr_r;
  logic              latch_rise;

  assign latch_rise = latch_s & ~latch_prev_r;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      latch_prev_r <= 1'b0;
      lat_sel_r    <= 1'b0;
      lat_addr_r   <= '0;
    end else begin
      latch_prev_r <= latch_s;
      if (latch_rise) begin
        lat_sel_r  <= live_sel;
        lat_addr_r <= live_addr;
      end
    end
  end

  logic              eff_sel;
  logic [ADDR_W-1:0] eff_addr;
  logic              rd_act;
  logic              wr_act;

  // Strobe low passes the pins straight through; high holds the latched copy
  assign eff_sel  = (latch_s && !latch_rise) ? lat_sel_r  : live_sel;
  assign eff_addr = (latch_s && !latch_rise) ? lat_addr_r : live_addr;
  assign rd_act   = eff_sel & rd_req;
  assign wr_act   = eff_sel & wr_req;

  logic rd_prev_r;
  logic wr_prev_r;
  logic wr_rise;
  logic rd_fall;

  assign wr_rise = wr_act & ~wr_prev_r;
  assign rd_fall = ~rd_act & rd_prev_r;

  // Address held over the whole read so the pop hits the register that was read
  logic [ADDR_W-1:0] rd_addr_r;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
      rd_addr_r <= '0;
    end else begin
      rd_prev_r <= rd_act;
      wr_prev_r <= wr_act;
      if (rd_act && !rd_prev_r) begin
        rd_addr_r <= eff_addr;
      end
    end
  end

  // ****************************************
  // Transmit buffer
  // ****************************************
  logic [DATA_W-1:0] tx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0]  tx_wp_r;
  logic [PTR_W-1:0]  tx_rp_r;
  logic              tx_full;
  logic              tx_empty;
  logic              tx_push;
  logic              tx_pop;

  assign tx_full  = ((tx_wp_r - tx_rp_r) == PTR_W'(FIFO_DEPTH)) ||
                    (((tx_wp_r - tx_rp_r) == PTR_W'(FIFO_DEPTH - 1)) && tx_valid_out);
  assign tx_empty = (tx_wp_r == tx_rp_r);
  assign tx_push  = wr_rise && (eff_addr == DATA_OFFSET) && !tx_full;
  assign tx_pop   = tx_valid_out && tx_ready_in;

  always_ff @(posedge ref_clk_in) begin
    if (tx_push) begin
      tx_mem[tx_wp_r[PTR_W-2:0]] <= wdata;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      tx_wp_r      <= '0;
      tx_rp_r      <= '0;
      tx_valid_out <= 1'b0;
      tx_data_out  <= DATA_RESET;
    end else begin
      if (tx_push) begin
        tx_wp_r <= tx_wp_r + 1'b1;
      end
      if (!tx_valid_out || tx_pop) begin
        tx_valid_out <= !tx_empty;
        if (!tx_empty) begin
          tx_data_out <= tx_mem[tx_rp_r[PTR_W-2:0]];
          tx_rp_r     <= tx_rp_r + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Receive buffer
  // ****************************************
  logic [DATA_W+ERR_W-1:0] rx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0]        rx_wp_r;
  logic [PTR_W-1:0]        rx_rp_r;
  logic                    rx_full;
  logic                    rx_empty;
  logic                    rx_push;
  logic                    rx_pop;
  logic [DATA_W+ERR_W-1:0] rx_head;

  assign rx_full  = (rx_wp_r[PTR_W-1] != rx_rp_r[PTR_W-1]) &&
                    (rx_wp_r[PTR_W-2:0] == rx_rp_r[PTR_W-2:0]);
  assign rx_empty = (rx_wp_r == rx_rp_r);
  assign rx_push  = rx_valid_in && rx_ready_out;
  assign rx_pop   = rd_fall && (rd_addr_r == DATA_OFFSET) && !rx_empty;
  assign rx_head  = rx_mem[rx_rp_r[PTR_W-2:0]];

  always_ff @(posedge ref_clk_in) begin
    if (rx_push) begin
      rx_mem[rx_wp_r[PTR_W-2:0]] <= {rx_err_in, rx_data_in};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      rx_wp_r      <= '0;
      rx_rp_r      <= '0;
      rx_ready_out <= 1'b0;
    end else begin
      rx_ready_out <= !rx_full && !(rx_push && rx_wp_r[PTR_W-2:0] + 1'b1 == rx_rp_r[PTR_W-2:0]);
      if (rx_push) begin
        rx_wp_r <= rx_wp_r + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_r <= rx_rp_r + 1'b1;
      end
    end
  end

  // ****************************************
  // Other registers, shadowed for read back
  // ****************************************
  logic [DATA_W-1:0] shadow_r [1 << ADDR_W];

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < (1 << ADDR_W); i++) begin
        shadow_r[i] <= DATA_RESET;
      end
      reg_wr_valid_out <= 1'b0;
      reg_wr_addr_out  <= '0;
      reg_wr_data_out  <= DATA_RESET;
    end else begin
      reg_wr_valid_out <= wr_rise && (eff_addr != DATA_OFFSET) && (eff_addr != STATUS_OFFSET);
      if (wr_rise && (eff_addr != DATA_OFFSET) && (eff_addr != STATUS_OFFSET)) begin
        shadow_r[eff_addr] <= wdata;
        reg_wr_addr_out    <= eff_addr;
        reg_wr_data_out    <= wdata;
      end
    end
  end

  // ****************************************
  // Read data and bus drivers
  // ****************************************
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] rd_data;

  always_comb begin
    status = '0;
    status[STAT_RX_AVAIL_POS]                   = !rx_empty;
    status[STAT_RX_ERR_POS +: ERR_W]            = rx_empty ? '0 : rx_head[DATA_W +: ERR_W];
    status[STAT_TX_EMPTY_POS]                   = tx_empty && !tx_valid_out;
    status[STAT_TX_FULL_POS]                    = tx_full;
  end

  always_comb begin
    if (eff_addr == DATA_OFFSET) begin
      rd_data = rx_empty ? DATA_RESET : rx_head[DATA_W-1:0];
    end else if (eff_addr == STATUS_OFFSET) begin
      rd_data = status;
    end else begin
      rd_data = shadow_r[eff_addr];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      bus.dev_data_out    <= DATA_RESET;
      bus.dev_data_oe_n   <= 1'b1;
      bus.drive_disable_n <= 1'b1;
    end else begin
      bus.dev_data_oe_n   <= !rd_act;
      bus.drive_disable_n <= !rd_act;
      if (rd_act && !rd_prev_r) begin
        bus.dev_data_out <= rd_data;
      end
    end
  end

endmodule

// ### uart_bus_port_host.sv
// Host end: runs single register accesses on the parallel bus port pins
module uart_bus_port_host
  import uart_bus_port_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              resetn_in,
  uart_bus_port_if.host_end      bus,
  input  wire logic              use_hi_strobe_in,
  input  wire logic              use_addr_latch_in,
  input  wire logic              cmd_valid_in,
  input  wire logic              cmd_write_in,
  input  wire logic [ADDR_W-1:0] cmd_addr_in,
  input  wire logic [DATA_W-1:0] cmd_wdata_in,
  output logic                   cmd_ready_out,
  output logic                   rsp_valid_out,
  output logic [DATA_W-1:0]      rsp_rdata_out
);

  // ****************************************
  // Read data synchroniser
  // ****************************************
  logic [DATA_W-1:0] rd_meta_r;
  logic [DATA_W-1:0] rd_sync_r;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      rd_meta_r <= '0;
      rd_sync_r <= '0;
    end else begin
      rd_meta_r <= bus.host_data_bus;
      rd_sync_r <= rd_meta_r;
    end
  end

  // ****************************************
  // Access sequencer
  // ****************************************
  host_state_t      state_r;
  logic [CNT_W-1:0] cnt_r;
  logic             is_wr_r;
  logic             hi_r;
  logic             latch_r;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_r       <= H_IDLE;
      cnt_r         <= '0;
      is_wr_r       <= 1'b0;
      hi_r          <= 1'b0;
      latch_r       <= 1'b0;
      cmd_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= DATA_RESET;
    end else begin
      rsp_valid_out <= 1'b0;
      cnt_r         <= cnt_r + 1'b1;
      unique case (state_r)
        H_IDLE: begin
          cmd_ready_out <= 1'b1;
          cnt_r         <= '0;
          if (cmd_valid_in && cmd_ready_out) begin
            cmd_ready_out <= 1'b0;
            is_wr_r       <= cmd_write_in;
            hi_r          <= use_hi_strobe_in;
            latch_r       <= use_addr_latch_in;
            state_r       <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (cnt_r == CNT_W'(SETUP_CYCLES - 1)) begin
            cnt_r   <= '0;
            state_r <= latch_r ? H_LATCH : H_STROBE;
          end
        end
        H_LATCH: begin
          if (cnt_r == CNT_W'(SETUP_CYCLES - 1)) begin
            cnt_r   <= '0;
            state_r <= H_STROBE;
          end
        end
        H_STROBE: begin
          if (cnt_r == CNT_W'(STROBE_CYCLES - 1)) begin
            cnt_r   <= '0;
            state_r <= H_RECOV;
            if (!is_wr_r) begin
              rsp_rdata_out <= rd_sync_r;
            end
            rsp_valid_out <= 1'b1;
          end
        end
        H_RECOV: begin
          if (cnt_r == CNT_W'(RECOV_CYCLES - 1)) begin
            cnt_r   <= '0;
            state_r <= H_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  logic active;
  logic strobing;

  assign active   = (state_r != H_IDLE);
  assign strobing = (state_r == H_STROBE);

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      bus.select_high_a     <= 1'b0;
      bus.select_high_b     <= 1'b1;
      bus.select_low_c      <= 1'b0;
      bus.addr_latch_strobe <= 1'b0;
      bus.reg_select_bit0   <= 1'b0;
      bus.reg_select_bit1   <= 1'b0;
      bus.reg_select_bit2   <= 1'b0;
      bus.read_strobe_hi    <= 1'b0;
      bus.read_strobe_lo    <= 1'b1;
      bus.write_strobe_hi   <= 1'b0;
      bus.write_strobe_lo   <= 1'b1;
      bus.host_data_out     <= DATA_RESET;
      bus.host_data_oe_n    <= 1'b1;
    end else begin
      // Only the first select decodes; the spare two sit at their active level
      bus.select_high_a <= (cmd_valid_in && cmd_ready_out) || (active && state_r != H_RECOV);
      bus.select_high_b <= 1'b1;
      bus.select_low_c  <= 1'b0;
      bus.addr_latch_strobe <= latch_r && active &&
                               (state_r == H_LATCH || strobing);
      if (cmd_valid_in && cmd_ready_out) begin
        {bus.reg_select_bit2, bus.reg_select_bit1, bus.reg_select_bit0} <= cmd_addr_in;
        bus.host_data_out <= cmd_wdata_in;
      end
      bus.read_strobe_hi  <= strobing && !is_wr_r && hi_r;
      bus.read_strobe_lo  <= !(strobing && !is_wr_r && !hi_r);
      bus.write_strobe_hi <= strobing && is_wr_r && hi_r;
      bus.write_strobe_lo <= !(strobing && is_wr_r && !hi_r);
      bus.host_data_oe_n  <= !(is_wr_r && active) && !(cmd_valid_in && cmd_ready_out && cmd_write_in);
    end
  end

endmodule

// ### uart_host_bus_port_properties.sv
// Pin-level checks on the link between the bus port device and host ends
module uart_host_bus_port_properties
  import uart_bus_port_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic reg_select_bit0,
  input wire logic reg_select_bit1,
  input wire logic reg_select_bit2,
  input wire logic read_strobe_hi,
  input wire logic read_strobe_lo,
  input wire logic write_strobe_hi,
  input wire logic write_strobe_lo,
  input wire logic select_high_a,
  input wire logic select_high_b,
  input wire logic select_low_c,
  input wire logic addr_latch_strobe,
  input wire logic drive_disable_n,
  input wire logic host_data_oe_n,
  input wire logic dev_data_oe_n
);
  logic       sel;
  logic       rd_act;
  logic       wr_act;
  logic [5:0] rd_hist_r;

  assign sel    = select_high_a && select_high_b && !select_low_c;
  assign rd_act = sel && (read_strobe_hi || !read_strobe_lo);
  assign wr_act = sel && (write_strobe_hi || !write_strobe_lo);

  // Recent history of selected reads, covers the device's pin pipeline
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      rd_hist_r <= 6'h00;
    end else begin
      rd_hist_r <= {rd_hist_r[4:0], rd_act};
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  // ****************************************
  // Assertions
  // ****************************************
  disable_follows_oe_a: assert property (dev_data_oe_n == drive_disable_n)
    else $error("drive disable differs from data enable");
  no_bus_clash_a: assert property (!dev_data_oe_n |-> host_data_oe_n)
    else $error("both ends drive the data bus");
  read_turn_on_a: assert property ($rose(rd_act) |-> ##[1:3] !dev_data_oe_n)
    else $error("device did not drive read data");
  bus_released_a: assert property ((rd_hist_r == 6'h00 && !rd_act) |-> dev_data_oe_n)
    else $error("device drives bus without a selected read");
  strobe_pair_a: assert property (!(read_strobe_hi && !read_strobe_lo)
    && !(write_strobe_hi && !write_strobe_lo))
    else $error("both strobe forms active at once");
  unused_sel_a: assert property (select_high_b && !select_low_c)
    else $error("unused selects not parked active");
  strobe_hold_a: assert property ($rose(rd_act) |-> rd_act [*8])
    else $error("read strobe shorter than eight cycles");
  latch_stable_a: assert property ((addr_latch_strobe && $past(addr_latch_strobe))
    |-> $stable({reg_select_bit2, reg_select_bit1, reg_select_bit0}) && sel)
    else $error("latched address or select moved");
  write_data_a: assert property (wr_act |-> !host_data_oe_n)
    else $error("write strobe without host data");

  cover property ($rose(sel && !read_strobe_lo));
  cover property ($rose(sel && read_strobe_hi));
  cover property ($rose(wr_act));
  cover property ($rose(addr_latch_strobe));
endmodule

// ### uart_host_bus_port_tb.sv
// Self-checking bench joining the host and device ends of the bus port
module uart_host_bus_port_tb import uart_bus_port_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic              ref_clk_in = 1'b0;
  logic              resetn_in = 1'b0;
  logic              use_hi_strobe_in = 1'b0;
  logic              use_addr_latch_in = 1'b0;
  logic              cmd_valid_in = 1'b0;
  logic              cmd_write_in = 1'b0;
  logic [ADDR_W-1:0] cmd_addr_in = 3'h0;
  logic [DATA_W-1:0] cmd_wdata_in = 8'h00;
  logic              tx_ready_in = 1'b0;
  logic [DATA_W-1:0] rx_data_in = 8'h00;
  logic [ERR_W-1:0]  rx_err_in = 3'h0;
  logic              rx_valid_in = 1'b0;
  wire               cmd_ready_out, rsp_valid_out, tx_valid_out, rx_ready_out, reg_wr_valid_out;
  wire [DATA_W-1:0]  rsp_rdata_out, tx_data_out, reg_wr_data_out;
  wire [ADDR_W-1:0]  reg_wr_addr_out;
  int                fail_count = 0;
  int                comparisons = 0;
  int                wr_pulses = 0;
  logic [DATA_W-1:0] tx_q[$];
  logic [DATA_W-1:0] rd_data, d;
  logic [ADDR_W-1:0] a, last_addr;
  logic [DATA_W-1:0] last_data;

  always #10 ref_clk_in = ~ref_clk_in;

  uart_bus_port_if bus_if ();
  uart_bus_port_dev uart_bus_port_dev_i (.ref_clk_in, .resetn_in, .bus(bus_if), .tx_data_out,
    .tx_valid_out, .tx_ready_in, .rx_data_in, .rx_err_in, .rx_valid_in, .rx_ready_out,
    .reg_wr_valid_out, .reg_wr_addr_out, .reg_wr_data_out);
  uart_bus_port_host uart_bus_port_host_i (.ref_clk_in, .resetn_in, .bus(bus_if),
    .use_hi_strobe_in, .use_addr_latch_in, .cmd_valid_in, .cmd_write_in, .cmd_addr_in,
    .cmd_wdata_in, .cmd_ready_out, .rsp_valid_out, .rsp_rdata_out);
  uart_host_bus_port_properties uart_host_bus_port_properties_i (.ref_clk_in, .resetn_in,
    .reg_select_bit0(bus_if.reg_select_bit0), .reg_select_bit1(bus_if.reg_select_bit1),
    .reg_select_bit2(bus_if.reg_select_bit2), .read_strobe_hi(bus_if.read_strobe_hi),
    .read_strobe_lo(bus_if.read_strobe_lo), .write_strobe_hi(bus_if.write_strobe_hi),
    .write_strobe_lo(bus_if.write_strobe_lo), .select_high_a(bus_if.select_high_a),
    .select_high_b(bus_if.select_high_b), .select_low_c(bus_if.select_low_c),
    .addr_latch_strobe(bus_if.addr_latch_strobe), .drive_disable_n(bus_if.drive_disable_n),
    .host_data_oe_n(bus_if.host_data_oe_n), .dev_data_oe_n(bus_if.dev_data_oe_n));

  // ****************************************
  // Monitors on the device's user side
  // ****************************************
  always @(posedge ref_clk_in) begin
    if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) tx_q.push_back(tx_data_out);
    if (reg_wr_valid_out === 1'b1) begin
      wr_pulses++;
      last_addr = reg_wr_addr_out;
      last_data = reg_wr_data_out;
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic access(input logic wr, input logic [2:0] adr, input logic [7:0] wd,
                        input logic hi, input logic lat, output logic [7:0] q);
    int n;
    q = 8'h00;
    @(negedge ref_clk_in);
    while (cmd_ready_out !== 1'b1) @(negedge ref_clk_in);
    cmd_valid_in = 1'b1;
    cmd_write_in = wr;
    cmd_addr_in = adr;
    cmd_wdata_in = wd;
    use_hi_strobe_in = hi;
    use_addr_latch_in = lat;
    @(negedge ref_clk_in);
    cmd_valid_in = 1'b0;
    for (n = 0; n < 40 && cmd_ready_out !== 1'b1; n++) begin
      if (rsp_valid_out === 1'b1) q = rsp_rdata_out;
      @(negedge ref_clk_in);
    end
    check("access done", {7'h00, cmd_ready_out}, 8'h01);
  endtask

  task automatic push(input logic [7:0] pd, input logic [2:0] pe);
    @(negedge ref_clk_in);
    while (rx_ready_out !== 1'b1) @(negedge ref_clk_in);
    rx_valid_in = 1'b1;
    rx_data_in = pd;
    rx_err_in = pe;
    @(negedge ref_clk_in);
    rx_valid_in = 1'b0;
  endtask

  function automatic logic [7:0] stat(input logic av, input logic [2:0] er, input logic em,
                                      input logic fu);
    return {1'b0, fu, em, 1'b0, er, av};
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #(20 * 20000);
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (5) @(negedge ref_clk_in);
    check("reset disable", {7'h00, bus_if.drive_disable_n}, 8'h01);
    check("reset enables", {6'h00, bus_if.dev_data_oe_n, bus_if.host_data_oe_n}, 8'h03);
    check("reset valids", {6'h00, tx_valid_out, reg_wr_valid_out}, 8'h00);
    resetn_in = 1'b1;
    // Plain registers in every strobe and latch mode
    for (int i = 0; i < 6; i++) begin
      a = (i < 4) ? 3'(i + 1) : 3'(i + 2);
      d = {5'h0b, a} ^ (i[0] ? 8'hff : 8'h00);
      access(1'b1, a, d, i[0], i[1], rd_data);
      check("write address", {5'h00, last_addr}, {5'h00, a});
      check("write data", last_data, d);
      access(1'b0, a, 8'h00, !i[0], i[1] ^ i[2], rd_data);
      check("read back", rd_data, d);
    end
    check("write pulses", 8'(wr_pulses), 8'h06);
    access(1'b0, STATUS_OFFSET, 8'h00, 1'b0, 1'b0, rd_data);
    check("status idle", rd_data & 8'h6f, stat(1'b0, 3'h0, 1'b1, 1'b0));
    // Transmit buffer filled past its depth, then drained
    for (int i = 0; i < 17; i++) access(1'b1, DATA_OFFSET, 8'(i) ^ 8'ha5, i[0], 1'b0, rd_data);
    access(1'b0, STATUS_OFFSET, 8'h00, 1'b1, 1'b1, rd_data);
    check("status full", rd_data & 8'h6f, stat(1'b0, 3'h0, 1'b0, 1'b1));
    tx_ready_in = 1'b1;
    for (int n = 0; n < 100 && (n < 4 || tx_valid_out === 1'b1); n++) @(negedge ref_clk_in);
    check("sent count", 8'(tx_q.size()), 8'h10);
    for (int i = 0; i < 16 && i < tx_q.size(); i++) begin
      check("sent byte", tx_q[i], 8'(i) ^ 8'ha5);
    end
    access(1'b0, STATUS_OFFSET, 8'h00, 1'b0, 1'b0, rd_data);
    check("status drained", rd_data & 8'h6f, stat(1'b0, 3'h0, 1'b1, 1'b0));
    // Receive buffer filled to depth with error flags, then read out
    for (int i = 0; i < 16; i++) push(8'(i) ^ 8'h3c, 3'(i));
    for (int i = 0; i < 16; i++) begin
      access(1'b0, STATUS_OFFSET, 8'h00, i[1], i[0], rd_data);
      check("status head", rd_data & 8'h6f, stat(1'b1, 3'(i), 1'b1, 1'b0));
      access(1'b0, DATA_OFFSET, 8'h00, i[0], i[1], rd_data);
      check("received byte", rd_data, 8'(i) ^ 8'h3c);
    end
    access(1'b0, STATUS_OFFSET, 8'h00, 1'b0, 1'b0, rd_data);
    check("status empty", rd_data & 8'h6f, stat(1'b0, 3'h0, 1'b1, 1'b0));
    access(1'b0, DATA_OFFSET, 8'h00, 1'b0, 1'b0, rd_data);
    check("empty read", rd_data, DATA_RESET);
    print_verdict();
  end
endmodule
